// file: rtl/isp_defines.vh
// constants for the serial programming instruction engine
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH
`define OP_ENABLE_ERASE   8'hac
`define OP_POLL           8'hf0
`define OP_LOAD_EXT       8'h4d
`define OP_LOAD_HIGH      8'h48
`define OP_LOAD_LOW       8'h40
`define OP_LOAD_EE_PAGE   8'hc1
`define OP_READ_HIGH      8'h28
`define OP_READ_LOW       8'h20
`define OP_READ_EE        8'ha0
`define OP_READ_LOCK_FH   8'h58
`define OP_READ_SIG       8'h30
`define OP_READ_FUSE_EF   8'h50
`define OP_READ_CAL       8'h38
`define OP_WRITE_PAGE     8'h4c
`define OP_WRITE_EE       8'hc0
`define OP_WRITE_EE_PAGE  8'hc2
`define SUB_ENABLE        8'h53
`define SUB_ERASE         8'h80
`define SUB_WRITE_LOCK    8'he0
`define SUB_FUSE_HIGH     8'h08
`define ERASED_BYTE       8'hff
`define RESET_LOCK        8'hff
`define CLK_SYS_MHZ       100
`define PAGE_WRITE_WAIT_US   4500
`define EEPROM_WRITE_WAIT_US 9000
`define CHIP_ERASE_WAIT_US   9000
`define PAGE_WRITE_WAIT_CYC   (`PAGE_WRITE_WAIT_US * `CLK_SYS_MHZ)
`define EEPROM_WRITE_WAIT_CYC (`EEPROM_WRITE_WAIT_US * `CLK_SYS_MHZ)
`define CHIP_ERASE_WAIT_CYC   (`CHIP_ERASE_WAIT_US * `CLK_SYS_MHZ)
`endif

// file: rtl/pin_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module pin_sync (
	// clock and reset
	input  wire i_clk_sys,
	input  wire i_rst,
	// pin in, filtered level out
	input  wire i_pin,
	output reg  o_level
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				o_level <= s3;
			end
		end
	end
endmodule // pin_sync

// file: rtl/serial_isp_instruction_engine.v
// serial in-system programming instruction engine
//
// Behaviour
// - mosi bits are sampled on rising serial clock edges
// - miso bits change on falling serial clock edges
// - echo 0x53 during byte three when in sync; programmer sends all four
// - write page commits buffer word 0 only, at address 14..8 plus bit 0 of stored extended byte
// - eeprom byte write self-erases, busy 9.0 ms
// - chip erase sets flash and eeprom to ff, busy 9.0 ms
// - reads return addressed content; flash msb from extended byte
// - decode ac 53 as enable and ac 80 as chip erase
// - decode 4d as load extended address and store it
// - decode 48 and 40 as page buffer high and low loads
// - decode c1 as eeprom page buffer load with 2-bit address
// - decode c0 write, a0 read, c2 page write on 11-bit eeprom address
// - decode 28 and 20 as flash high and low byte reads
// - return lock, fuses, signature and calibration in byte four
// - reset released high leaves programming mode
// - program and erase accepted only after successful enable
// - poll reply bit 0 is one while an operation is pending
// - decode ac e0 00 as lock write; zero means programmed
`timescale 1ns/100ps
`include "isp_defines.vh"
module serial_isp_instruction_engine #(
	parameter [31:0] PAGE_WRITE_WAIT_CYC   = `PAGE_WRITE_WAIT_CYC,
	parameter [31:0] EEPROM_WRITE_WAIT_CYC = `EEPROM_WRITE_WAIT_CYC,
	parameter [31:0] CHIP_ERASE_WAIT_CYC   = `CHIP_ERASE_WAIT_CYC,
	parameter [7:0]  SIG_BYTE0             = 8'h1e, // arbitrary
	parameter [7:0]  SIG_BYTE1             = 8'h2a, // arbitrary
	parameter [7:0]  SIG_BYTE2             = 8'h03, // arbitrary
	parameter [7:0]  CAL_BYTE              = 8'h80,
	parameter [7:0]  FUSE_LOW              = 8'h62,
	parameter [7:0]  FUSE_HIGH             = 8'h99,
	parameter [7:0]  FUSE_EXT              = 8'hff
) (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rst,
	// serial programming pins
	input  wire        i_reset_pin,
	input  wire        i_sck,
	input  wire        i_mosi,
	output reg         o_miso,
	// memory write side
	output reg         o_flash_we,
	output reg  [15:0] o_flash_addr,
	output reg  [15:0] o_flash_data,
	output reg         o_ee_we,
	output reg  [10:0] o_ee_addr,
	output reg  [7:0]  o_ee_data,
	output reg         o_chip_erase,
	output reg  [7:0]  o_lock_bits,
	output reg         o_prog_mode,
	// memory read side
	input  wire [15:0] i_flash_rdata,
	input  wire [7:0]  i_ee_rdata
);
	// ****************************************************
	// pin synchronisers
	// ****************************************************
	wire sck_s;
	wire mosi_s;
	wire rst_s;
	pin_sync u_sck (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_sck), .o_level(sck_s));
	pin_sync u_mosi (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_mosi), .o_level(mosi_s));
	pin_sync u_rst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_reset_pin),
		.o_level(rst_s));

	// ****************************************************
	// state
	// ****************************************************
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;
	reg        sck_d;
	reg [4:0]  bit_cnt;
	reg [31:0] shift_in;
	reg [7:0]  shift_out;
	reg        enabled;
	reg [7:0]  ext_addr;
	reg [7:0]  page_lo [0:127];
	reg [7:0]  page_hi [0:127];
	reg [7:0]  ee_page [0:3];
	reg        state;
	reg [31:0] wait_cnt;
	reg [7:0]  read_byte;
	reg [7:0]  read_addr;
	wire rise = sck_s & ~sck_d;
	wire fall = ~sck_s & sck_d;
	wire [31:0] word = {shift_in[30:0], mosi_s};
	wire [7:0]  op = word[31:24];
	wire [7:0]  b2 = word[23:16];
	wire [7:0]  b3 = word[15:8];
	wire [7:0]  b4 = word[7:0];
	wire        busy = (state == ST_BUSY);
	integer i;

	// byte returned in byte four for a read opcode
	function [7:0] read_value;
		input [7:0]  fop;
		input [7:0]  fb2;
		input [7:0]  fb3;
		input [15:0] fdata;
		input [7:0]  fee;
		input [7:0]  flock;
		input        fbusy;
		begin
			read_value = 8'h00;
			if (fop == `OP_POLL) begin
				read_value = {7'h00, fbusy};
			end else if (fop == `OP_READ_HIGH) begin
				read_value = fdata[15:8];
			end else if (fop == `OP_READ_LOW) begin
				read_value = fdata[7:0];
			end else if (fop == `OP_READ_EE) begin
				read_value = fee;
			end else if (fop == `OP_READ_LOCK_FH) begin
				read_value = (fb2 == `SUB_FUSE_HIGH) ? FUSE_HIGH : flock;
			end else if (fop == `OP_READ_FUSE_EF) begin
				read_value = (fb2 == `SUB_FUSE_HIGH) ? FUSE_EXT : FUSE_LOW;
			end else if (fop == `OP_READ_SIG) begin
				read_value = (fb3[1:0] == 2'd0) ? SIG_BYTE0 :
					(fb3[1:0] == 2'd1) ? SIG_BYTE1 : SIG_BYTE2;
			end else if (fop == `OP_READ_CAL) begin
				read_value = CAL_BYTE;
			end
		end
	endfunction

	// ****************************************************
	// shifter, decoder and write sequencer
	// ****************************************************
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sck_d        <= 1'b0;
			bit_cnt      <= 5'd0;
			shift_in     <= 32'h0;
			shift_out    <= 8'h00;
			o_miso       <= 1'b0;
			enabled      <= 1'b0;
			ext_addr     <= 8'h00;
			state        <= ST_IDLE;
			wait_cnt     <= 32'h0;
			read_byte    <= 8'h00;
			read_addr    <= 8'h00;
			o_flash_we   <= 1'b0;
			o_flash_addr <= 16'h0000;
			o_flash_data <= 16'h0000;
			o_ee_we      <= 1'b0;
			o_ee_addr    <= 11'h000;
			o_ee_data    <= 8'h00;
			o_chip_erase <= 1'b0;
			o_lock_bits  <= `RESET_LOCK;
			o_prog_mode  <= 1'b0;
			for (i = 0; i < 128; i = i + 1) begin
				page_lo[i] <= `ERASED_BYTE;
				page_hi[i] <= `ERASED_BYTE;
			end
			for (i = 0; i < 4; i = i + 1) begin
				ee_page[i] <= `ERASED_BYTE;
			end
		end else begin
			sck_d        <= sck_s;
			o_flash_we   <= 1'b0;
			o_ee_we      <= 1'b0;
			o_chip_erase <= 1'b0;
			o_prog_mode  <= enabled & ~rst_s;
			if (busy) begin
				if (wait_cnt <= 32'd1) begin
					state <= ST_IDLE;
				end
				wait_cnt <= wait_cnt - 32'd1;
			end
			if (rst_s) begin
				enabled <= 1'b0;
				bit_cnt <= 5'd0;
			end else if (rise) begin
				shift_in <= word;
				bit_cnt  <= bit_cnt + 5'd1;
				if (bit_cnt == 5'd23) begin
					// latch read address ahead of byte four
					o_flash_addr <= {ext_addr[0], word[14:8], word[7:0]};
					o_ee_addr    <= {word[10:8], word[7:0]};
					read_addr    <= word[7:0];
				end
				if (bit_cnt == 5'd31) begin
					bit_cnt <= 5'd0;
					if (op == `OP_ENABLE_ERASE && b2 == `SUB_ENABLE) begin
						enabled <= 1'b1;
					end
					if (enabled && !busy) begin
						if (op == `OP_ENABLE_ERASE && b2 == `SUB_ERASE) begin
							o_chip_erase <= 1'b1;
							o_lock_bits  <= `RESET_LOCK;
							state        <= ST_BUSY;
							wait_cnt     <= CHIP_ERASE_WAIT_CYC;
						end else if (op == `OP_ENABLE_ERASE && b2 == `SUB_WRITE_LOCK) begin
							o_lock_bits <= b4;
						end else if (op == `OP_LOAD_EXT) begin
							ext_addr <= b3;
						end else if (op == `OP_LOAD_HIGH) begin
							page_hi[b3[6:0]] <= b4;
						end else if (op == `OP_LOAD_LOW) begin
							page_lo[b3[6:0]] <= b4;
						end else if (op == `OP_LOAD_EE_PAGE) begin
							ee_page[b3[1:0]] <= b4;
						end else if (op == `OP_WRITE_PAGE) begin
							o_flash_addr <= {ext_addr[0], b2[6:0], 8'h00};
							state        <= ST_BUSY;
							wait_cnt     <= PAGE_WRITE_WAIT_CYC;
							o_flash_we   <= 1'b1;
						end else if (op == `OP_WRITE_EE) begin
							o_ee_addr <= {b2[2:0], b3};
							o_ee_data <= b4;
							o_ee_we   <= 1'b1;
							state     <= ST_BUSY;
							wait_cnt  <= EEPROM_WRITE_WAIT_CYC;
						end else if (op == `OP_WRITE_EE_PAGE) begin
							// page write with low bits zero
							o_ee_addr <= {b2[2:0], b3[7:2], 2'b00};
							o_ee_data <= ee_page[0];
							o_ee_we   <= 1'b1;
							state     <= ST_BUSY;
							wait_cnt  <= EEPROM_WRITE_WAIT_CYC;
						end
					end
				end
			end else if (fall) begin
				if (bit_cnt == 5'd16) begin
					// echo second byte during byte three
					shift_out <= {shift_in[6:0], 1'b0};
					o_miso    <= shift_in[7];
				end else if (bit_cnt == 5'd24) begin
					shift_out <= {read_byte[6:0], 1'b0};
					o_miso    <= read_byte[7];
				end else if (bit_cnt > 5'd16) begin
					shift_out <= {shift_out[6:0], 1'b0};
					o_miso    <= shift_out[7];
				end
			end
			// read data captured once the address is latched
			read_byte <= read_value(shift_in[23:16], shift_in[15:8], read_addr,
				o_flash_we ? {page_hi[7'd0], page_lo[7'd0]} : i_flash_rdata,
				i_ee_rdata, o_lock_bits, busy);
			if (o_flash_we) begin
				o_flash_data <= {page_hi[o_flash_addr[7:1]], page_lo[o_flash_addr[7:1]]};
			end
		end
	end
endmodule // serial_isp_instruction_engine

// file: test/isp_engine_sva.sv
// checker for the serial programming instruction engine
`timescale 1ns/100ps
module isp_engine_sva (
	// clock and reset
	input wire       i_clk_sys,
	input wire       i_rst,
	// pins and outputs
	input wire       i_reset_pin,
	input wire       i_sck,
	input wire       o_miso,
	input wire       o_flash_we,
	input wire       o_ee_we,
	input wire       o_chip_erase,
	input wire [7:0] o_lock_bits,
	input wire       o_prog_mode
);
	wire wr = o_flash_we | o_ee_we | o_chip_erase;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	flash_pulse_a: assert property (o_flash_we |=> !o_flash_we)
		else $error("flash commit longer than one cycle");
	ee_pulse_a: assert property (o_ee_we |=> !o_ee_we)
		else $error("eeprom write longer than one cycle");
	erase_pulse_a: assert property (o_chip_erase |=> !o_chip_erase)
		else $error("erase pulse longer than one cycle");
	write_gate_a: assert property (wr |-> o_prog_mode && $past(o_prog_mode))
		else $error("write outside programming mode");
	pin_exit_a: assert property (i_reset_pin [*8] |-> !o_prog_mode)
		else $error("programming mode kept with reset pin high");
	miso_edge_a: assert property ($changed(o_miso) |-> !i_sck)
		else $error("serial output moved while clock high");
	lock_reset_a: assert property ($fell(i_rst) |-> o_lock_bits == 8'hff)
		else $error("lock byte not unprogrammed after reset");
	lock_gate_a: assert property ($changed(o_lock_bits) |-> $past(o_prog_mode))
		else $error("lock byte changed outside programming mode");
	commit_gap_a: assert property (wr |=> !wr [*8])
		else $error("two commits too close together");
endmodule // isp_engine_sva

bind serial_isp_instruction_engine isp_engine_sva u_isp_engine_sva (.i_clk_sys(i_clk_sys),
	.i_rst(i_rst), .i_reset_pin(i_reset_pin), .i_sck(i_sck), .o_miso(o_miso),
	.o_flash_we(o_flash_we), .o_ee_we(o_ee_we), .o_chip_erase(o_chip_erase),
	.o_lock_bits(o_lock_bits), .o_prog_mode(o_prog_mode));

// file: test/isp_programmer.sv
// behavioural in-system programmer driving the serial pins
`timescale 1ns/100ps
module isp_programmer (
	// clock
	input  wire i_clk_sys,
	// serial programming pins
	output reg  o_reset_pin,
	output reg  o_sck,
	output reg  o_mosi,
	input  wire i_miso
);
	initial begin
		o_reset_pin = 1'b0;
		o_sck = 1'b0;
		o_mosi = 1'b0;
	end
	task power_up;
		begin
			o_sck = 1'b0;
			o_reset_pin = 1'b1;
			repeat (3) @(negedge i_clk_sys);
			o_reset_pin = 1'b0;
			repeat (200) @(negedge i_clk_sys);
		end
	endtask
	task xfer(input [31:0] cmd, output [31:0] rx);
		integer n;
		begin
			for (n = 31; n >= 0; n = n - 1) begin
				o_mosi = cmd[n];
				repeat (8) @(negedge i_clk_sys);
				rx[n] = i_miso;
				o_sck = 1'b1;
				repeat (8) @(negedge i_clk_sys);
				o_sck = 1'b0;
			end
			o_mosi = ~o_mosi;
			repeat (8) @(negedge i_clk_sys);
		end
	endtask
endmodule // isp_programmer

// file: test/testbench.sv
// self-checking bench for the serial programming instruction engine
`timescale 1ns/100ps
module testbench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	wire        reset_pin, sck, mosi, miso, flash_we, ee_we, chip_erase, prog_mode;
	wire [15:0] flash_addr, flash_data, flash_rdata;
	wire [10:0] ee_addr;
	wire [7:0]  ee_data, ee_rdata, lock_bits;
	integer     bad_count = 0, checked = 0, cycles = 0, n_fw = 0, n_ew = 0, n_ce = 0, k;
	reg  [31:0] rx;
	reg  [15:0] cap_addr, cap_data;
	reg  [18:0] cap_ee;
	reg         fw_d = 1'b0;
	// b1 b2 b3 and expected reply
	localparam [255:0] CFG = {32'h580000ff, 32'h50000062, 32'h58080099, 32'h500800fd,
		32'h3000001e, 32'h3000012a, 32'h30000203, 32'h3800005e};
	always #5 clk = ~clk;
	assign flash_rdata = {flash_addr[7:0] ^ 8'ha5, flash_addr[7:0] ^ 8'h3c};
	assign ee_rdata = ee_addr[7:0] ^ 8'h3c;
	always @(posedge clk) begin
		cycles = cycles + 1;
		n_fw = n_fw + (flash_we === 1'b1);
		n_ew = n_ew + (ee_we === 1'b1);
		n_ce = n_ce + (chip_erase === 1'b1);
		fw_d <= flash_we;
		if (flash_we === 1'b1) cap_addr <= flash_addr;
		if (fw_d) cap_data <= flash_data;
		if (ee_we === 1'b1) cap_ee <= {ee_addr, ee_data};
		if (cycles == 60000) begin
			bad_count = bad_count + 1;
			wrap_up;
		end
	end
	isp_programmer u_isp_programmer (.i_clk_sys(clk), .o_reset_pin(reset_pin),
		.o_sck(sck), .o_mosi(mosi), .i_miso(miso));
	serial_isp_instruction_engine #(.PAGE_WRITE_WAIT_CYC(32'd2000),
		.EEPROM_WRITE_WAIT_CYC(32'd2000), .CHIP_ERASE_WAIT_CYC(32'd2000),
		.CAL_BYTE(8'h5e), .FUSE_EXT(8'hfd)) u_serial_isp_instruction_engine (
		.i_clk_sys(clk), .i_rst(rst), .i_reset_pin(reset_pin), .i_sck(sck), .i_mosi(mosi),
		.o_miso(miso), .o_flash_we(flash_we), .o_flash_addr(flash_addr),
		.o_flash_data(flash_data), .o_ee_we(ee_we), .o_ee_addr(ee_addr), .o_ee_data(ee_data),
		.o_chip_erase(chip_erase), .o_lock_bits(lock_bits), .o_prog_mode(prog_mode),
		.i_flash_rdata(flash_rdata), .i_ee_rdata(ee_rdata));
	task check(input [8*8:1] what, input [18:0] seen, input [18:0] want);
		begin
			checked = checked + 1;
			if (seen !== want) begin
				bad_count = bad_count + 1;
				$display("BAD %0s want %h seen %h", what, want, seen);
			end
		end
	endtask
	task send(input [31:0] c);
		u_isp_programmer.xfer(c, rx);
	endtask
	task poll_busy;
		begin
			send(32'hf0000000);
			check("busy", rx[0], 1'b1);
			for (k = 0; k < 10 && rx[0] !== 1'b0; k = k + 1)
				send(32'hf0000000);
			check("ready", rx[0], 1'b0);
		end
	endtask
	task t_enable;
		begin
			send(32'hac800000);
			check("early", n_ce, 0);
			send(32'hac530000);
			check("echo", rx[15:8], 8'h53);
			check("mode", prog_mode, 1'b1);
			send(32'hac800000);
			check("erase", n_ce, 1);
			poll_busy;
		end
	endtask
	task t_flash;
		begin
			send(32'h4d000100);
			send(32'h40000034);
			send(32'h48000012);
			send(32'h4c120000);
			check("fw", n_fw, 1);
			check("fwdata", cap_data, 16'h1234);
			check("fwaddr", cap_addr, 16'h9200);
			poll_busy;
			send(32'h20002100);
			check("rdlow", rx[7:0], 8'h1d);
			send(32'h28002100);
			check("rdhigh", rx[7:0], 8'h84);
		end
	endtask
	task t_eeprom;
		begin
			send(32'hc0023477);
			check("ew", n_ew, 1);
			check("ewdata", cap_ee, {11'h234, 8'h77});
			poll_busy;
			send(32'ha0012300);
			check("eeread", rx[7:0], 8'h1f);
			send(32'hc1000055);
			send(32'hc2012300);
			check("ew2", n_ew, 2);
			check("ewpage", cap_ee, {11'h120, 8'h55});
			poll_busy;
			for (k = 0; k < 8; k = k + 1) begin
				send({CFG[k*32+8 +: 24], 8'h00});
				check("config", rx[7:0], CFG[k*32 +: 8]);
			end
		end
	endtask
	task t_lock_exit;
		begin
			send(32'hace000f0);
			check("lock", lock_bits, 8'hf0);
			send(32'hff000000);
			send(32'hc3000000);
			check("undef", n_fw + n_ew + n_ce, 4);
			force_pin_high;
			check("exit", prog_mode, 1'b0);
			send(32'hac800000);
			check("noerase", n_ce, 1);
		end
	endtask
	task force_pin_high;
		begin
			u_isp_programmer.o_reset_pin = 1'b1;
			repeat (20) @(negedge clk);
		end
	endtask
	task wrap_up;
		begin
			if (bad_count == 0 && checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		u_isp_programmer.power_up;
		t_enable;
		t_flash;
		t_eeprom;
		t_lock_exit;
		wrap_up;
	end
endmodule // testbench
